// ---- ocb_config_bank.sv ----
// one-time configuration bank and the charger decisions that it steers
`timescale 1ns/1ns
`default_nettype none
module ocb_config_bank
  import ocb_pkg::*;
#(
  parameter int VW = VOLT_W
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  output logic                   otp_rd_req,
  output logic [ADDR_W-1:0]      otp_addr,
  input  wire logic              otp_rd_ack,
  input  wire logic [DATA_W-1:0] otp_rdata,
  input  wire logic              input_startup,
  input  wire logic [VW-1:0]     battery_voltage,
  input  wire logic [VW-1:0]     recharge_threshold,
  input  wire logic              termination_met,
  input  wire logic              balancing_active,
  input  wire logic              charge_suspended,
  input  wire logic [TEMP_W-1:0] die_temp,
  output logic                   config_ready,
  output logic                   charge_start,
  output logic                   restart_blocked,
  output logic                   end_of_charge,
  output logic [TEMP_W-1:0]      thermal_limit,
  output logic                   thermal_regulating,
  output logic                   dcdc_switch_en
);

  ocb_cfg_type cfg;
  logic        loaded;

  ////////////////////////////////////////////////////////////////////////////
  // the only source of the two banks is the one-time array read port
  ocb_otp_loader u_loader (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .otp_rd_req (otp_rd_req),
    .otp_addr   (otp_addr),
    .otp_rd_ack (otp_rd_ack),
    .otp_rdata  (otp_rdata),
    .cfg        (cfg),
    .loaded     (loaded)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decisions
  logic              startup_pend_reg;
  logic              startup_pend_next;
  logic              charge_start_reg;
  logic              charge_start_next;
  logic              restart_blocked_reg;
  logic              restart_blocked_next;
  logic              end_of_charge_reg;
  logic              end_of_charge_next;
  logic [TEMP_W-1:0] thermal_limit_reg;
  logic [TEMP_W-1:0] thermal_limit_next;
  logic              thermal_regulating_reg;
  logic              thermal_regulating_next;
  logic              dcdc_switch_en_reg;
  logic              dcdc_switch_en_next;
  logic              config_ready_reg;
  logic              startup_seen;
  logic              above_recharge;

  assign startup_seen   = startup_pend_reg || input_startup;
  assign above_recharge = battery_voltage > recharge_threshold;

  always_comb
  begin
    startup_pend_next       = startup_pend_reg;
    charge_start_next       = 1'b0;
    restart_blocked_next    = 1'b0;
    end_of_charge_next      = 1'b0;
    thermal_limit_next      = thermal_limit_reg;
    thermal_regulating_next = 1'b0;
    dcdc_switch_en_next     = 1'b0;
    // start-up before the load completes is kept pending, not lost
    if (!loaded)
    begin
      startup_pend_next = startup_seen;
    end
    else
    begin
      startup_pend_next = 1'b0;
      if (startup_seen && above_recharge)
      begin
        charge_start_next    = cfg.auto_restart_setting;
        restart_blocked_next = !cfg.auto_restart_setting;
      end
      end_of_charge_next = termination_met &&
                           !(cfg.balance_hold_setting && balancing_active);
      thermal_limit_next      = tj_limit(cfg.tj_code);
      thermal_regulating_next = die_temp >= tj_limit(cfg.tj_code);
      dcdc_switch_en_next     = !charge_suspended || cfg.switching_keep_setting;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      startup_pend_reg       <= 1'b0;
      charge_start_reg       <= 1'b0;
      restart_blocked_reg    <= 1'b0;
      end_of_charge_reg      <= 1'b0;
      thermal_limit_reg      <= TJ_LIMIT_120;
      thermal_regulating_reg <= 1'b0;
      dcdc_switch_en_reg     <= 1'b0;
      config_ready_reg       <= 1'b0;
    end
    else
    begin
      startup_pend_reg       <= startup_pend_next;
      charge_start_reg       <= charge_start_next;
      restart_blocked_reg    <= restart_blocked_next;
      end_of_charge_reg      <= end_of_charge_next;
      thermal_limit_reg      <= thermal_limit_next;
      thermal_regulating_reg <= thermal_regulating_next;
      dcdc_switch_en_reg     <= dcdc_switch_en_next;
      config_ready_reg       <= loaded;
    end
  end

  assign config_ready       = config_ready_reg;
  assign charge_start       = charge_start_reg;
  assign restart_blocked    = restart_blocked_reg;
  assign end_of_charge      = end_of_charge_reg;
  assign thermal_limit      = thermal_limit_reg;
  assign thermal_regulating = thermal_regulating_reg;
  assign dcdc_switch_en     = dcdc_switch_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  auto_restart_on_a: assert property (
    (loaded && input_startup && above_recharge && cfg.auto_restart_setting)
      |=> charge_start)
    else $error("start-up above recharge threshold did not start a charge");

  auto_restart_off_a: assert property (
    (charge_start || restart_blocked)
      |-> $past(loaded) && $past(startup_seen) && $past(above_recharge)
          && (charge_start == $past(cfg.auto_restart_setting)))
    else $error("charge start does not follow the auto-restart setting");

  balance_hold_a: assert property (
    end_of_charge |-> $past(termination_met) &&
      !($past(cfg.balance_hold_setting) && $past(balancing_active)))
    else $error("end of charge raised while balancing was held");

  balance_free_a: assert property (
    (loaded && termination_met && !cfg.balance_hold_setting) |=> end_of_charge)
    else $error("termination blocked although hold is off");

  tj_select_a: assert property (
    $past(loaded) |-> thermal_limit ==
      (($past(cfg.tj_code) == 2'h0) ? 8'h78 : ($past(cfg.tj_code) == 2'h1) ? 8'h64 :
       ($past(cfg.tj_code) == 2'h2) ? 8'h50 : 8'h3C))
    else $error("thermal limit does not match the junction code");

  switch_keep_a: assert property (
    (loaded && charge_suspended) |=> (dcdc_switch_en == $past(cfg.switching_keep_setting)))
    else $error("switching while suspended does not follow its setting");

  load_first_a: assert property (
    !loaded |=> !(charge_start || end_of_charge || dcdc_switch_en || thermal_regulating))
    else $error("decision made before the configuration was loaded");

  bank_read_a: assert property (
    otp_rd_req |-> (otp_addr == 8'h05 || otp_addr == 8'h06))
    else $error("one-time read outside the two banks");

  ready_after_load_a: assert property (
    loaded |=> config_ready)
    else $error("configuration ready did not follow the load");

  pend_start_a: assert property (
    ($rose(loaded) && startup_pend_reg && above_recharge)
      |=> (charge_start || restart_blocked))
    else $error("start-up seen during the load was not served");

  restart_low_a: assert property (
    (loaded && startup_seen && !above_recharge) |=> !(charge_start || restart_blocked))
    else $error("restart decision taken below the recharge threshold");

  eoc_clear_a: assert property (
    (loaded && !termination_met) |=> !end_of_charge)
    else $error("end of charge raised without termination");

  tj_regulate_a: assert property (
    loaded |=> (thermal_regulating == ($past(die_temp) >= thermal_limit)))
    else $error("thermal regulation does not follow the selected limit");

  switch_idle_a: assert property (
    (loaded && !charge_suspended) |=> dcdc_switch_en)
    else $error("switching stopped while charging is not suspended");

  read_hold_a: assert property (
    (otp_rd_req && !otp_rd_ack) |=> (otp_rd_req && $stable(otp_addr)))
    else $error("one-time read request dropped before its answer");

  read_order_a: assert property (
    (otp_rd_req && otp_rd_ack && (otp_addr == CHARGE_POLICY_ADDR))
      |=> (otp_rd_req && (otp_addr == SWITCHING_POLICY_ADDR)))
    else $error("second bank not read after the first");

  restart_c: cover property (loaded && input_startup && above_recharge ##1 charge_start);
  held_eoc_c: cover property (loaded && termination_met && balancing_active
                              && cfg.balance_hold_setting);
  suspend_c: cover property (loaded && charge_suspended ##1 dcdc_switch_en);
  early_startup_c: cover property (!loaded && input_startup);
  blocked_c: cover property (loaded && input_startup && above_recharge
                             && !cfg.auto_restart_setting);

endmodule
`default_nettype wire

// ---- ocb_config_bank_tb_top.sv ----
// self-checking bench for the one-time configuration bank
`timescale 1ns/1ns
`default_nettype none
module ocb_config_bank_tb_top
  import ocb_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic              otp_rd_ack = 1'b0;
  logic [DATA_W-1:0] otp_rdata = 8'h00;
  logic              input_startup = 1'b0;
  logic [11:0]       battery_voltage = 12'h800;
  logic [11:0]       recharge_threshold = 12'h700;
  logic              termination_met = 1'b0;
  logic              balancing_active = 1'b0;
  logic              charge_suspended = 1'b0;
  logic [TEMP_W-1:0] die_temp = 8'h00;
  logic              otp_rd_req;
  logic [ADDR_W-1:0] otp_addr;
  logic              config_ready;
  logic              charge_start;
  logic              restart_blocked;
  logic              end_of_charge;
  logic [TEMP_W-1:0] thermal_limit;
  logic              thermal_regulating;
  logic              dcdc_switch_en;
  int                num_errors = 0;
  int                samples_checked = 0;

  ocb_config_bank #(.VW(12)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .otp_rd_req(otp_rd_req), .otp_addr(otp_addr),
    .otp_rd_ack(otp_rd_ack), .otp_rdata(otp_rdata), .input_startup(input_startup),
    .battery_voltage(battery_voltage), .recharge_threshold(recharge_threshold),
    .termination_met(termination_met), .balancing_active(balancing_active),
    .charge_suspended(charge_suspended), .die_temp(die_temp), .config_ready(config_ready),
    .charge_start(charge_start), .restart_blocked(restart_blocked),
    .end_of_charge(end_of_charge), .thermal_limit(thermal_limit),
    .thermal_regulating(thermal_regulating), .dcdc_switch_en(dcdc_switch_en)
  );

  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // answers one bank read; nothing may start before the bank is loaded
  task automatic serve(input logic [7:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    while (otp_rd_req !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(16'(otp_addr), 16'(addr));
    check(16'(charge_start), 16'h0);
    otp_rd_ack = 1'b1;
    otp_rdata = data;
    @(negedge clk_sys);
    otp_rd_ack = 1'b0;
    otp_rdata = ~data;
  endtask

  // reset, then load both banks; su gives a start-up pending during the load
  task automatic load(input logic [7:0] b5, input logic [7:0] b6, input logic su);
    logic [15:0] pulses;
    logic        rdy;
    pulses = 16'h0;
    rdy = 1'b0;
    rst_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(16'(thermal_limit), 16'h78);
    check(16'(config_ready), 16'h0);
    rst_n = 1'b1;
    input_startup = su;
    @(negedge clk_sys);
    input_startup = 1'b0;
    serve(8'h05, b5);
    @(negedge clk_sys);
    serve(8'h06, b6);
    repeat (6)
    begin
      if (charge_start === 1'b1) pulses++;
      if (config_ready === 1'b1) rdy = 1'b1;
      @(negedge clk_sys);
    end
    check(16'(otp_rd_req), 16'h0);
    check(16'(rdy), 16'h1);
    check(pulses, 16'(su & b5[7]));
  endtask

  task automatic restart(input logic [11:0] batt, input logic cs, input logic rb);
    battery_voltage = batt;
    input_startup = 1'b1;
    @(negedge clk_sys);
    check(16'(charge_start), 16'(cs));
    check(16'(restart_blocked), 16'(rb));
    input_startup = 1'b0;
    @(negedge clk_sys);
    check(16'({charge_start, restart_blocked}), 16'h0);
    battery_voltage = 12'h800;
  endtask

  task automatic eoc(input logic hold);
    termination_met = 1'b1;
    balancing_active = 1'b1;
    @(negedge clk_sys);
    check(16'(end_of_charge), 16'(!hold));
    balancing_active = 1'b0;
    @(negedge clk_sys);
    check(16'(end_of_charge), 16'h1);
    termination_met = 1'b0;
    @(negedge clk_sys);
    check(16'(end_of_charge), 16'h0);
  endtask

  task automatic thermal;
    logic [7:0] lim [4];
    lim = '{8'h78, 8'h64, 8'h50, 8'h3C};
    for (int c = 0; c < 4; c++)
    begin
      load({3'h7, c[1:0], 3'h0}, 8'h03, 1'b0);
      die_temp = lim[c];
      @(negedge clk_sys);
      check(16'(thermal_limit), 16'(lim[c]));
      check(16'(thermal_regulating), 16'h1);
      die_temp = lim[c] - 8'h01;
      @(negedge clk_sys);
      check(16'(thermal_regulating), 16'h0);
    end
  endtask

  task automatic switching(input logic keep);
    load(8'hE0, {7'h01, keep}, 1'b0);
    charge_suspended = 1'b1;
    @(negedge clk_sys);
    check(16'(dcdc_switch_en), 16'(keep));
    charge_suspended = 1'b0;
    @(negedge clk_sys);
    check(16'(dcdc_switch_en), 16'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    load(8'hE0, 8'h03, 1'b1);
    eoc(1'b1);
    restart(12'h800, 1'b1, 1'b0);
    restart(12'h700, 1'b0, 1'b0);
    load(8'h40, 8'h03, 1'b1);
    eoc(1'b0);
    restart(12'h800, 1'b0, 1'b1);
    thermal;
    switching(1'b1);
    switching(1'b0);
    results;
  end

  // cut a hang short well past the expected run of under two hundred cycles
  initial
  begin
    #200000;
    num_errors++;
    results;
  end
endmodule
`default_nettype wire

// ---- ocb_otp_loader.sv ----
// reads the two one-time banks after reset and holds them as shadow bytes
`timescale 1ns/1ns
`default_nettype none
module ocb_otp_loader
  import ocb_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  output logic                   otp_rd_req,
  output logic [ADDR_W-1:0]      otp_addr,
  input  wire logic              otp_rd_ack,
  input  wire logic [DATA_W-1:0] otp_rdata,
  output ocb_cfg_type            cfg,
  output logic                   loaded
);

  ocb_load_state_type state_reg;
  ocb_load_state_type state_next;
  logic [DATA_W-1:0]  charge_byte_reg;
  logic [DATA_W-1:0]  charge_byte_next;
  logic [DATA_W-1:0]  switch_byte_reg;
  logic [DATA_W-1:0]  switch_byte_next;

  always_comb
  begin
    state_next       = state_reg;
    charge_byte_next = charge_byte_reg;
    switch_byte_next = switch_byte_reg;
    case (state_reg)
      LD_IDLE:
        state_next = LD_CHARGE;
      LD_CHARGE:
        if (otp_rd_ack)
        begin
          charge_byte_next = otp_rdata;
          state_next       = LD_SWITCH;
        end
      LD_SWITCH:
        if (otp_rd_ack)
        begin
          switch_byte_next = otp_rdata;
          state_next       = LD_DONE;
        end
      default:
        state_next = LD_DONE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg       <= LD_IDLE;
      charge_byte_reg <= CHARGE_POLICY_RESET;
      switch_byte_reg <= SWITCHING_POLICY_RESET;
    end
    else
    begin
      state_reg       <= state_next;
      charge_byte_reg <= charge_byte_next;
      switch_byte_reg <= switch_byte_next;
    end
  end

  assign otp_rd_req = (state_reg == LD_CHARGE) || (state_reg == LD_SWITCH);
  assign otp_addr   = (state_reg == LD_SWITCH) ? SWITCHING_POLICY_ADDR : CHARGE_POLICY_ADDR;
  assign loaded     = (state_reg == LD_DONE);
  // one driver for the whole struct keeps the shadow fields in a single assignment
  assign cfg = '{
    auto_restart_setting:   charge_byte_reg[AUTO_RESTART_BIT],
    balance_hold_setting:   charge_byte_reg[BALANCE_HOLD_BIT],
    tj_code:                charge_byte_reg[TJ_CODE_HI:TJ_CODE_LO],
    switching_keep_setting: switch_byte_reg[SWITCHING_KEEP_BIT]
  };

endmodule
`default_nettype wire

// ---- ocb_pkg.sv ----
// constants and types shared by the one-time configuration bank
`default_nettype none
package ocb_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int VOLT_W = 12;
  localparam int TEMP_W = 8;

  // bank locations in the one-time array
  localparam logic [ADDR_W-1:0] CHARGE_POLICY_ADDR    = 8'h05;
  localparam logic [ADDR_W-1:0] SWITCHING_POLICY_ADDR = 8'h06;

  // values held before the array has been read
  localparam logic [DATA_W-1:0] CHARGE_POLICY_RESET    = 8'hE0;
  localparam logic [DATA_W-1:0] SWITCHING_POLICY_RESET = 8'h03;

  // field positions in charge_policy_otp
  localparam int AUTO_RESTART_BIT = 7;
  localparam int BALANCE_HOLD_BIT = 5;
  localparam int TJ_CODE_HI       = 4;
  localparam int TJ_CODE_LO       = 3;
  // field position in switching_policy_otp
  localparam int SWITCHING_KEEP_BIT = 0;

  // junction regulation thresholds in degrees
  localparam logic [1:0]        TJ_CODE_120 = 2'h0;
  localparam logic [1:0]        TJ_CODE_100 = 2'h1;
  localparam logic [1:0]        TJ_CODE_80  = 2'h2;
  localparam logic [TEMP_W-1:0] TJ_LIMIT_120 = 8'h78;
  localparam logic [TEMP_W-1:0] TJ_LIMIT_100 = 8'h64;
  localparam logic [TEMP_W-1:0] TJ_LIMIT_80  = 8'h50;
  localparam logic [TEMP_W-1:0] TJ_LIMIT_60  = 8'h3C;

  typedef struct packed {
    logic       auto_restart_setting;
    logic       balance_hold_setting;
    logic [1:0] tj_code;
    logic       switching_keep_setting;
  } ocb_cfg_type;

  typedef enum logic [2:0] {
    LD_IDLE     = 3'b000,
    LD_CHARGE   = 3'b001,
    LD_SWITCH   = 3'b010,
    LD_DONE     = 3'b011
  } ocb_load_state_type;

  function automatic logic [TEMP_W-1:0] tj_limit(input logic [1:0] code);
    if (code == TJ_CODE_120) return TJ_LIMIT_120;
    else if (code == TJ_CODE_100) return TJ_LIMIT_100;
    else if (code == TJ_CODE_80) return TJ_LIMIT_80;
    else return TJ_LIMIT_60;
  endfunction

endpackage
`default_nettype wire
